//--- pkg/clh_consts.vh
// constants for the character display instruction port
`ifndef CLH_CONSTS_VH
`define CLH_CONSTS_VH

// clock period and execution times, in ns
`define CLH_CLK_NS 25
`define CLH_T_CLEAR_NS 1530000
`define CLH_T_HOME_NS 1530000
`define CLH_T_CMD_NS 39000
`define CLH_T_DATA_NS 43000

// execution times in clock cycles, rounded up
`define CLH_CYC_CLEAR ((`CLH_T_CLEAR_NS + `CLH_CLK_NS - 1) / `CLH_CLK_NS)
`define CLH_CYC_HOME ((`CLH_T_HOME_NS + `CLH_CLK_NS - 1) / `CLH_CLK_NS)
`define CLH_CYC_CMD ((`CLH_T_CMD_NS + `CLH_CLK_NS - 1) / `CLH_CLK_NS)
`define CLH_CYC_DATA ((`CLH_T_DATA_NS + `CLH_CLK_NS - 1) / `CLH_CLK_NS)
`define CLH_BUSY_W 16

// memory sizes
`define CLH_TEXT_DEPTH 128
`define CLH_GLYPH_DEPTH 64

// reset and fixed values
`define CLH_SPACE_CODE 8'h20
`define CLH_HOME_ADDR 7'h00
`define CLH_RST_WIDTH8 1'b1
`define CLH_RST_STEP_UP 1'b1

// register byte offsets
`define CLH_AXI_AW 12
`define CLH_REG_STATUS 12'h000
`define CLH_REG_SETTINGS 12'h004
`define CLH_REG_PEEK_ADDR 12'h008
`define CLH_REG_PEEK_DATA 12'h00C

// status register fields
`define CLH_ST_AC_LSB 0
`define CLH_ST_BUSY 7
`define CLH_ST_GLYPH 8
`define CLH_ST_WIDTH8 9
`define CLH_ST_NIBBLE 10

// settings register fields
`define CLH_SE_DISP 0
`define CLH_SE_CURSOR 1
`define CLH_SE_BLINK 2
`define CLH_SE_LINES 3
`define CLH_SE_FONT 4
`define CLH_SE_STEP_UP 5
`define CLH_SE_SHIFT_EN 6
`define CLH_SE_OFFSET_LSB 8

// bus responses
`define CLH_RESP_OKAY 2'b00
`define CLH_RESP_SLVERR 2'b10

`endif

//--- src/clh_instr_port.v
// instruction interpreter of a character display controller, host bus side
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "clh_consts.vh"

module clh_instr_port #(
    parameter integer CLEAR_CYCLES = `CLH_CYC_CLEAR,
    parameter integer HOME_CYCLES = `CLH_CYC_HOME
) (
    input wire clock_i,
    input wire rstn_i,
    input wire register_select_i,
    input wire read_write_i,
    input wire strobe_i,
    input wire [7:0] bus_lines_i,
    output reg [7:0] bus_lines_o,
    output wire [7:0] bus_lines_oe_o,
    input wire [`CLH_AXI_AW-1:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [`CLH_AXI_AW-1:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i
);

    localparam integer CMD_CYCLES = `CLH_CYC_CMD;
    localparam integer DATA_CYCLES = `CLH_CYC_DATA;
    localparam [`CLH_BUSY_W-1:0] BUSY_ZERO = 16'h0000;
    localparam [`CLH_BUSY_W-1:0] BUSY_ONE = 16'h0001;

    // pin synchronisers
    reg strobe_s1, strobe_s2, strobe_d;
    reg select_s1, select_s2;
    reg rw_s1, rw_s2;
    reg [7:0] lines_s1, lines_s2;

    // values seen while the strobe is high, used at its fall
    reg cap_select;
    reg cap_rw;
    reg [7:0] cap_lines;

    // interpreter state
    reg width8;
    reg nib_second;
    reg [3:0] hi_nib;
    reg [6:0] address_counter;
    reg sel_glyph;
    reg step_up;
    reg whole_view_shift;
    reg disp_on;
    reg cursor_on;
    reg blink_on;
    reg two_lines;
    reg tall_font;
    reg [6:0] view_offset;
    reg [7:0] out_data;
    reg [`CLH_BUSY_W-1:0] busy_count;
    reg [7:0] text_mem [0:`CLH_TEXT_DEPTH-1];
    reg [7:0] glyph_mem [0:`CLH_GLYPH_DEPTH-1];
    integer i;

    // bus slave state
    reg aw_got;
    reg w_got;
    reg [`CLH_AXI_AW-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [6:0] peek_addr;

    wire internal_operation_flag = (busy_count != BUSY_ZERO);
    wire strobe_fall = strobe_d & ~strobe_s2;
    wire byte_done = strobe_fall & (width8 | nib_second);
    wire [7:0] full_byte = width8 ? cap_lines : {hi_nib, cap_lines[7:4]};
    // while busy only the status read is honoured; the host is expected to poll
    wire take_cmd = byte_done & ~cap_select & ~cap_rw & ~internal_operation_flag;
    wire take_wr = byte_done & cap_select & ~cap_rw & ~internal_operation_flag;
    wire take_rd = byte_done & cap_select & cap_rw & ~internal_operation_flag;

    // counter step; glyph addresses wrap within six bits
    function [6:0] stepped;
        input [6:0] addr;
        input up;
        input glyph;
        reg [6:0] raw;
        begin
            raw = up ? addr + 7'h01 : addr - 7'h01;
            stepped = glyph ? {1'b0, raw[5:0]} : raw;
        end
    endfunction

    wire [6:0] next_ac = stepped(address_counter, step_up, sel_glyph);
    wire [6:0] shift_ac = stepped(address_counter, full_byte[2], sel_glyph);
    wire [7:0] next_ac_byte = sel_glyph ? glyph_mem[next_ac[5:0]] : text_mem[next_ac];
    wire [7:0] status_byte = {internal_operation_flag, address_counter};
    wire [7:0] read_byte = select_s2 ? out_data : status_byte;
    wire drive_bus = strobe_s2 & rw_s2;

    // lower lines stay released in 4-bit width
    assign bus_lines_oe_o = {{4{drive_bus}}, {4{drive_bus & width8}}};

    always @(posedge clock_i) begin
        if (!rstn_i) begin
            strobe_s1 <= 1'b0;
            strobe_s2 <= 1'b0;
            strobe_d <= 1'b0;
            select_s1 <= 1'b0;
            select_s2 <= 1'b0;
            rw_s1 <= 1'b0;
            rw_s2 <= 1'b0;
            lines_s1 <= 8'h00;
            lines_s2 <= 8'h00;
            cap_select <= 1'b0;
            cap_rw <= 1'b0;
            cap_lines <= 8'h00;
            bus_lines_o <= 8'h00;
        end else begin
            strobe_s1 <= strobe_i;
            strobe_s2 <= strobe_s1;
            strobe_d <= strobe_s2;
            select_s1 <= register_select_i;
            select_s2 <= select_s1;
            rw_s1 <= read_write_i;
            rw_s2 <= rw_s1;
            lines_s1 <= bus_lines_i;
            lines_s2 <= lines_s1;
            if (strobe_s2) begin
                cap_select <= select_s2;
                cap_rw <= rw_s2;
                cap_lines <= lines_s2;
            end
            if (width8) begin
                bus_lines_o <= read_byte;
            end else if (nib_second) begin
                bus_lines_o <= {read_byte[3:0], 4'h0};
            end else begin
                bus_lines_o <= {read_byte[7:4], 4'h0};
            end
        end
    end

    // nibble sequencing and instruction execution
    always @(posedge clock_i) begin
        if (!rstn_i) begin
            width8 <= `CLH_RST_WIDTH8;
            nib_second <= 1'b0;
            hi_nib <= 4'h0;
            address_counter <= `CLH_HOME_ADDR;
            sel_glyph <= 1'b0;
            step_up <= `CLH_RST_STEP_UP;
            whole_view_shift <= 1'b0;
            disp_on <= 1'b0;
            cursor_on <= 1'b0;
            blink_on <= 1'b0;
            two_lines <= 1'b0;
            tall_font <= 1'b0;
            view_offset <= 7'h00;
            out_data <= 8'h00;
            busy_count <= BUSY_ZERO;
        end else begin
            if (strobe_fall && !width8) begin
                // flag only rises once the low nibble has arrived
                nib_second <= ~nib_second;
                if (!nib_second) begin
                    hi_nib <= cap_lines[7:4];
                end
            end
            if (internal_operation_flag) begin
                busy_count <= busy_count - BUSY_ONE;
            end
            if (take_cmd) begin
                busy_count <= CMD_CYCLES[`CLH_BUSY_W-1:0];
                casez (full_byte)
                    8'b1???????: begin
                        address_counter <= full_byte[6:0];
                        sel_glyph <= 1'b0;
                        out_data <= text_mem[full_byte[6:0]];
                    end
                    8'b01??????: begin
                        address_counter <= {1'b0, full_byte[5:0]};
                        sel_glyph <= 1'b1;
                        out_data <= glyph_mem[full_byte[5:0]];
                    end
                    8'b001?????: begin
                        width8 <= full_byte[4];
                        two_lines <= full_byte[3];
                        tall_font <= full_byte[2];
                        nib_second <= 1'b0;
                    end
                    8'b0001????: begin
                        if (full_byte[3]) begin
                            // the view moves, the counter does not
                            if (full_byte[2]) begin
                                view_offset <= view_offset - 7'h01;
                            end else begin
                                view_offset <= view_offset + 7'h01;
                            end
                        end else begin
                            address_counter <= shift_ac;
                            if (!sel_glyph) begin
                                out_data <= text_mem[shift_ac];
                            end
                        end
                    end
                    8'b00001???: begin
                        disp_on <= full_byte[2];
                        cursor_on <= full_byte[1];
                        blink_on <= full_byte[0];
                    end
                    8'b000001??: begin
                        step_up <= full_byte[1];
                        whole_view_shift <= full_byte[0];
                    end
                    8'b0000001?: begin
                        address_counter <= `CLH_HOME_ADDR;
                        sel_glyph <= 1'b0;
                        view_offset <= 7'h00;
                        busy_count <= HOME_CYCLES[`CLH_BUSY_W-1:0];
                    end
                    8'b00000001: begin
                        address_counter <= `CLH_HOME_ADDR;
                        sel_glyph <= 1'b0;
                        step_up <= 1'b1;
                        view_offset <= 7'h00;
                        busy_count <= CLEAR_CYCLES[`CLH_BUSY_W-1:0];
                    end
                    default: begin
                        busy_count <= BUSY_ZERO;
                    end
                endcase
            end
            if (take_wr) begin
                busy_count <= DATA_CYCLES[`CLH_BUSY_W-1:0];
                // out_data is left alone, so a following read sees the older byte
                address_counter <= next_ac;
                if (whole_view_shift && !sel_glyph) begin
                    if (step_up) begin
                        view_offset <= view_offset + 7'h01;
                    end else begin
                        view_offset <= view_offset - 7'h01;
                    end
                end
            end
            if (take_rd) begin
                busy_count <= DATA_CYCLES[`CLH_BUSY_W-1:0];
                address_counter <= next_ac;
                // prefetch for the next read, stepping the way step_up points; reset sets it to up
                out_data <= next_ac_byte;
            end
        end
    end

    // storage: no reset; text is undefined until cleared or written, glyphs until written
    always @(posedge clock_i) begin
        if (take_cmd && full_byte == 8'h01) begin
            for (i = 0; i < `CLH_TEXT_DEPTH; i = i + 1) begin
                text_mem[i] <= `CLH_SPACE_CODE;
            end
        end
        if (take_wr) begin
            if (sel_glyph) begin
                glyph_mem[address_counter[5:0]] <= full_byte;
            end else begin
                text_mem[address_counter] <= full_byte;
            end
        end
    end

    // register bus slave
    assign s_axi_awready_o = ~aw_got & ~s_axi_bvalid_o;
    assign s_axi_wready_o = ~w_got & ~s_axi_bvalid_o;
    assign s_axi_arready_o = ~s_axi_rvalid_o;

    wire aw_fire = s_axi_awvalid_i & s_axi_awready_o;
    wire w_fire = s_axi_wvalid_i & s_axi_wready_o;
    wire ar_fire = s_axi_arvalid_i & s_axi_arready_o;

    reg [31:0] next_rdata;
    reg [1:0] next_rresp;

    always @* begin
        next_rdata = 32'h0000_0000;
        next_rresp = `CLH_RESP_OKAY;
        case (s_axi_araddr_i)
            `CLH_REG_STATUS: begin
                next_rdata[`CLH_ST_AC_LSB +: 7] = address_counter;
                next_rdata[`CLH_ST_BUSY] = internal_operation_flag;
                next_rdata[`CLH_ST_GLYPH] = sel_glyph;
                next_rdata[`CLH_ST_WIDTH8] = width8;
                next_rdata[`CLH_ST_NIBBLE] = nib_second;
            end
            `CLH_REG_SETTINGS: begin
                next_rdata[`CLH_SE_DISP] = disp_on;
                next_rdata[`CLH_SE_CURSOR] = cursor_on;
                next_rdata[`CLH_SE_BLINK] = blink_on;
                next_rdata[`CLH_SE_LINES] = two_lines;
                next_rdata[`CLH_SE_FONT] = tall_font;
                next_rdata[`CLH_SE_STEP_UP] = step_up;
                next_rdata[`CLH_SE_SHIFT_EN] = whole_view_shift;
                next_rdata[`CLH_SE_OFFSET_LSB +: 7] = view_offset;
            end
            `CLH_REG_PEEK_ADDR: begin
                next_rdata[6:0] = peek_addr;
            end
            `CLH_REG_PEEK_DATA: begin
                next_rdata[7:0] = text_mem[peek_addr];
            end
            default: begin
                next_rresp = `CLH_RESP_SLVERR;
            end
        endcase
    end

    always @(posedge clock_i) begin
        if (!rstn_i) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            peek_addr <= 7'h00;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `CLH_RESP_OKAY;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= `CLH_RESP_OKAY;
            s_axi_rdata_o <= 32'h0000_0000;
        end else begin
            if (aw_fire) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (w_fire) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (aw_got && w_got && !s_axi_bvalid_o) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                if (aw_addr == `CLH_REG_PEEK_ADDR) begin
                    s_axi_bresp_o <= `CLH_RESP_OKAY;
                    if (w_strb[0]) begin
                        peek_addr <= w_data[6:0];
                    end
                end else begin
                    // only the peek index is writable
                    s_axi_bresp_o <= `CLH_RESP_SLVERR;
                end
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            if (ar_fire) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= next_rdata;
                s_axi_rresp_o <= next_rresp;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

endmodule // clh_instr_port

//--- dv/clh_instr_port_chk.sv
// assertion checker for the character display instruction port
`timescale 1ns/10ps
module clh_instr_port_chk (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic strobe_i,
    input wire logic read_write_i,
    input wire logic [7:0] bus_lines_o,
    input wire logic [7:0] bus_lines_oe_o,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    sequence s_ar_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    sequence s_wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    a_write_no_drive: assert property (!read_write_i [*4] |-> bus_lines_oe_o == 8'h00)
        else $error("bus driven during a write");
    a_idle_no_drive: assert property (!strobe_i [*4] |-> bus_lines_oe_o == 8'h00)
        else $error("bus driven without strobe");
    a_drive_cause: assert property ($rose(bus_lines_oe_o[7]) |-> $past(strobe_i, 2) && $past(read_write_i, 2))
        else $error("bus drive without a read strobe");
    a_lower_whole: assert property (bus_lines_oe_o[3:0] != 4'h0 |-> bus_lines_oe_o == 8'hFF)
        else $error("lower lines driven alone");
    a_nibble_upper: assert property (bus_lines_oe_o == 8'hF0 |-> bus_lines_o[3:0] == 4'h0)
        else $error("lower lines carry data in nibble mode");
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data not held");
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid_o)
        else $error("write answer late");
    a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response not held");
endmodule // clh_instr_port_chk

bind clh_instr_port clh_instr_port_chk u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .strobe_i(strobe_i),
    .read_write_i(read_write_i), .bus_lines_o(bus_lines_o), .bus_lines_oe_o(bus_lines_oe_o),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));

//--- dv/clh_host_model.sv
// microprocessor model on the parallel display bus
`timescale 1ns/10ps
module clh_host_model #(
    parameter int HALF_OSC = 75
) (
    input wire logic clock_i,
    input wire logic [7:0] dut_q_i,
    input wire logic [7:0] dut_oe_i,
    output logic rs_o,
    output logic rw_o,
    output logic strobe_o,
    output wire logic [7:0] pins_o
);
    logic [7:0] val;
    logic [7:0] drv;
    logic [7:0] fill;
    logic w4;
    initial begin
        rs_o = 1'b0; rw_o = 1'b1; strobe_o = 1'b0; val = 8'h00; drv = 8'h00; fill = 8'h5A; w4 = 1'b0;
    end
    // undriven lines wander so a stale value can never pass for data
    always @(posedge clock_i) fill <= {fill[6:0], ~fill[7]};
    assign pins_o = (dut_oe_i & dut_q_i) | (~dut_oe_i & drv & val) | (~dut_oe_i & ~drv & fill);
    task automatic strobe1(input logic rs, input logic rw, input logic [7:0] v, output logic [7:0] got);
        @(posedge clock_i);
        rs_o <= rs; rw_o <= rw; val <= v; strobe_o <= 1'b1;
        drv <= rw ? 8'h00 : (w4 ? 8'hF0 : 8'hFF);
        repeat (6) @(posedge clock_i);
        got = pins_o;
        strobe_o <= 1'b0;
        repeat (3) @(posedge clock_i);
        drv <= 8'h00;
        rw_o <= 1'b1;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] v, output logic [7:0] got);
        logic [7:0] hi;
        logic [7:0] lo;
        if (w4) begin
            strobe1(rs, rw, {v[7:4], 4'h0}, hi);
            strobe1(rs, rw, {v[3:0], 4'h0}, lo);
            got = {hi[7:4], lo[7:4]};
        end else begin
            strobe1(rs, rw, v, got);
        end
    endtask
    task automatic settle;
        repeat (HALF_OSC) @(posedge clock_i);
    endtask
endmodule // clh_host_model

//--- dv/tb_clh_instr_port.sv
// self-checking bench for the character display instruction port
`timescale 1ns/10ps
`include "clh_consts.vh"
module tb_clh_instr_port;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, w;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, rs, rw, stb;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] pins, dq, doe;
    logic [7:0] d;
    logic [1:0] r;
    int fails = 0, check_count = 0;
    clh_instr_port #(.CLEAR_CYCLES(32'h0000_0032), .HOME_CYCLES(32'h0000_0032)) u_dut (.clock_i(clock_i),
        .rstn_i(rstn_i),
        .register_select_i(rs), .read_write_i(rw), .strobe_i(stb), .bus_lines_i(pins), .bus_lines_o(dq),
        .bus_lines_oe_o(doe), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    clh_host_model u_host (.clock_i(clock_i), .dut_q_i(dq), .dut_oe_i(doe), .rs_o(rs), .rw_o(rw),
        .strobe_o(stb), .pins_o(pins));
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic axi_rd(input logic [11:0] a);
        @(posedge clock_i);
        araddr <= a; arvalid <= 1'b1;
        @(posedge clock_i);
        while (!arready) @(posedge clock_i);
        arvalid <= 1'b0;
        @(posedge clock_i);
        while (rvalid !== 1'b1) @(posedge clock_i);
        rready <= 1'b1;
        @(posedge clock_i);
        w = rdata; r = rresp;
        rready <= 1'b0;
    endtask
    task automatic axi_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        axi_rd(a);
        chk(w, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
        logic aw_ok, w_ok;
        aw_ok = 1'b0; w_ok = 1'b0;
        @(posedge clock_i);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock_i);
            if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
        end
        while (bvalid !== 1'b1) @(posedge clock_i);
        bready <= 1'b1;
        @(posedge clock_i);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic wait_idle;
        d = 8'hFF;
        for (int i = 0; i < 400 && d[7] !== 1'b0; i++) u_host.xfer(1'b0, 1'b1, 8'h00, d);
        chk({24'h0, d[7], 7'h0}, 32'h0);
        u_host.settle();
    endtask
    task automatic cmd(input logic [7:0] c, input logic n4);
        u_host.xfer(1'b0, 1'b0, c, d);
        u_host.w4 = n4;
        wait_idle();
    endtask
    task automatic wr(input logic [7:0] v);
        u_host.xfer(1'b1, 1'b0, v, d);
        wait_idle();
    endtask
    task automatic rd_exp(input logic [7:0] e);
        u_host.xfer(1'b1, 1'b1, 8'h00, d);
        chk({24'h0, d}, {24'h0, e});
        wait_idle();
    endtask
    task automatic st_exp(input logic [6:0] ac);
        u_host.xfer(1'b0, 1'b1, 8'h00, d);
        chk({24'h0, d}, {25'h0, ac});
    endtask
    // flag must still stand at lo cycles and be gone by hi
    task automatic busy_win(input int lo, input int hi);
        repeat (lo) @(posedge clock_i);
        axi_rd(`CLH_REG_STATUS);
        chk({31'h0, w[7]}, 32'h1);
        repeat (hi - lo) @(posedge clock_i);
        axi_rd(`CLH_REG_STATUS);
        chk({31'h0, w[7]}, 32'h0);
        u_host.settle();
    endtask
    initial begin
        // the full sequence needs about 76000 cycles
        repeat (95000) @(posedge clock_i);
        fails++;
        final_report();
    end
    initial begin
        static logic [7:0] codes [7] = '{8'h07, 8'h04, 8'h06, 8'h3C, 8'h0B, 8'h0F, 8'h00};
        static logic [31:0] sets [7] = '{32'h0000_0067, 32'h0000_0007, 32'h0000_0027, 32'h0000_003F,
            32'h0000_003E, 32'h0000_003F, 32'h0000_003F};
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        axi_chk(`CLH_REG_STATUS, 32'h0000_0200, `CLH_RESP_OKAY);
        axi_chk(`CLH_REG_SETTINGS, 32'h0000_0020, `CLH_RESP_OKAY);
        axi_chk(12'h010, 32'h0000_0000, `CLH_RESP_SLVERR);
        axi_wr(`CLH_REG_STATUS, 32'h0000_0001);
        chk({30'h0, r}, {30'h0, `CLH_RESP_SLVERR});
        $display("test reset done");
        u_host.xfer(1'b0, 1'b0, 8'h0F, d);
        axi_rd(`CLH_REG_STATUS);
        chk({31'h0, w[7]}, 32'h1);
        u_host.xfer(1'b0, 1'b0, 8'h08, d);
        busy_win(1470, 1600);
        axi_chk(`CLH_REG_SETTINGS, 32'h0000_0027, `CLH_RESP_OKAY);
        for (int i = 0; i < 7; i++) begin
            cmd(codes[i], 1'b0);
            axi_chk(`CLH_REG_SETTINGS, sets[i], `CLH_RESP_OKAY);
        end
        $display("test commands done");
        cmd(8'h01, 1'b0);
        st_exp(7'h00);
        cmd(8'h80, 1'b0);
        rd_exp(8'h20);
        st_exp(7'h01);
        cmd(8'h85, 1'b0);
        wr(8'h41);
        wr(8'h42);
        st_exp(7'h07);
        axi_wr(`CLH_REG_PEEK_ADDR, 32'h0000_0005);
        axi_chk(`CLH_REG_PEEK_DATA, 32'h0000_0041, `CLH_RESP_OKAY);
        cmd(8'h80, 1'b0);
        wr(8'h55);
        rd_exp(8'h20);
        st_exp(7'h02);
        cmd(8'h85, 1'b0);
        rd_exp(8'h41);
        rd_exp(8'h42);
        cmd(8'h04, 1'b0);
        cmd(8'h86, 1'b0);
        rd_exp(8'h42);
        rd_exp(8'h41);
        st_exp(7'h04);
        cmd(8'h06, 1'b0);
        cmd(8'h85, 1'b0);
        cmd(8'h14, 1'b0);
        st_exp(7'h06);
        rd_exp(8'h42);
        cmd(8'h10, 1'b0);
        st_exp(7'h06);
        cmd(8'h18, 1'b0);
        axi_chk(`CLH_REG_SETTINGS, 32'h0000_013F, `CLH_RESP_OKAY);
        st_exp(7'h06);
        cmd(8'h02, 1'b0);
        axi_chk(`CLH_REG_SETTINGS, 32'h0000_003F, `CLH_RESP_OKAY);
        st_exp(7'h00);
        cmd(8'h1C, 1'b0);
        axi_chk(`CLH_REG_SETTINGS, 32'h0000_7F3F, `CLH_RESP_OKAY);
        $display("test text memory done");
        cmd(8'h43, 1'b0);
        wr(8'h1F);
        axi_chk(`CLH_REG_STATUS, 32'h0000_0304, `CLH_RESP_OKAY);
        cmd(8'h43, 1'b0);
        rd_exp(8'h1F);
        cmd(8'h90, 1'b0);
        u_host.xfer(1'b1, 1'b0, 8'h33, d);
        busy_win(1630, 1780);
        $display("test glyph and timing done");
        cmd(8'h2C, 1'b1);
        axi_rd(`CLH_REG_STATUS);
        chk({29'h0, w[10:8]}, 32'h0);
        u_host.strobe1(1'b0, 1'b0, 8'h90, d);
        axi_rd(`CLH_REG_STATUS);
        chk({30'h0, w[10], w[7]}, 32'h2);
        u_host.strobe1(1'b0, 1'b0, 8'h00, d);
        axi_rd(`CLH_REG_STATUS);
        chk({31'h0, w[7]}, 32'h1);
        wait_idle();
        wr(8'h5A);
        st_exp(7'h11);
        cmd(8'h90, 1'b1);
        rd_exp(8'h5A);
        cmd(8'h3C, 1'b0);
        cmd(8'h90, 1'b0);
        rd_exp(8'h5A);
        $display("test nibble mode done");
        final_report();
    end
endmodule // tb_clh_instr_port
